// ==== common/link_cmd_if.sv ====
`timescale 1ns/1ps
interface link_cmd_if;
    logic       rise;   // one-cycle pulse on a filtered ck_t rising edge
    logic       ck_t;   // filtered true clock level
    logic       ck_c;   // filtered complementary clock level
    logic       cke;    // filtered cke, valid with rise
    logic       cs_n;   // filtered chip select, valid with rise
    logic [2:0] ca;     // filtered ca0..ca2, valid with rise

    modport src (output rise, ck_t, ck_c, cke, cs_n, ca);
    modport dst (input  rise, ck_t, ck_c, cke, cs_n, ca);
endinterface : link_cmd_if

// ==== common/lp_ctl_pkg.sv ====
package lp_ctl_pkg;

    // =====================================================================
    // link timing
    // =====================================================================
    localparam int unsigned CLK_NS       = 100;     // local clock period
    localparam int unsigned STOP_NS      = 2000;    // link idle time that counts as a stopped clock
    // least time, so round up to whole cycles
    localparam int unsigned STOP_CYC     = (STOP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  STOP_CNT     = 8'(STOP_CYC);
    localparam logic [3:0]  MIN_EDGES    = 4'h2;    // stable link cycles around cke edges
    localparam logic [3:0]  EDGE_SAT     = 4'hF;    // saturation of edge counters

    // =====================================================================
    // command encodings on ca[2:0] (bit 0 is ca0)
    // =====================================================================
    localparam logic [2:0]  CA_NOP       = 3'h7;    // cs_n low, ca0..ca2 high
    localparam logic [2:0]  CA_DPD       = 3'h3;    // ca0 high, ca1 high, ca2 low

    // =====================================================================
    // sampler layout
    // =====================================================================
    localparam int unsigned PIN_W        = 7;       // {ck_t, ck_c, cke, cs_n, ca[2:0]}
    localparam int unsigned PIN_CK_T     = 6;
    localparam int unsigned PIN_CK_C     = 5;
    localparam int unsigned PIN_CKE      = 4;
    localparam int unsigned PIN_CS_N     = 3;

    // low-power state of the device
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_PD,
        ST_DPD,
        ST_INIT
    } lp_state_t;

endpackage : lp_ctl_pkg

// ==== logic/link_sampler.sv ====
`timescale 1ns/1ps
module link_sampler
    import lp_ctl_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // link pins
    input  wire logic       ck_t_i,
    input  wire logic       ck_c_i,
    input  wire logic       cke_i,
    input  wire logic       cs_n_i,
    input  wire logic [2:0] ca_i,
    // filtered view
    link_cmd_if.src         bus
);
    import lp_ctl_pkg::*;

    logic [PIN_W-1:0] pins;         // raw pin vector
    logic [PIN_W-1:0] sync1_ff;     // first stage, read only by the second
    logic [PIN_W-1:0] sync2_ff;     // second stage
    logic [PIN_W-1:0] sync3_ff;     // third stage
    logic [PIN_W-1:0] filt_ff;      // accepted level
    logic [PIN_W-1:0] nxt_filt;     // level accepted this cycle
    logic             rise_ff;      // ck_t edge pulse

    assign pins = {ck_t_i, ck_c_i, cke_i, cs_n_i, ca_i};

    // =====================================================================
    // three-stage synchroniser
    // =====================================================================
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else if (ce_i) begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // =====================================================================
    // per-bit agreement filter
    // =====================================================================
    // a change only counts once stages two and three agree, which hides a
    // metastable settle from the edge detector below
    for (genvar b = 0; b < PIN_W; b++) begin : g_filt
        assign nxt_filt[b] = (sync2_ff[b] == sync3_ff[b]) ? sync3_ff[b] : filt_ff[b];
    end

    // accepted levels and the ck_t rising-edge pulse
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_ff <= '0;
            rise_ff <= 1'b0;
        end else if (ce_i) begin
            filt_ff <= nxt_filt;
            rise_ff <= nxt_filt[PIN_CK_T] & ~filt_ff[PIN_CK_T];
        end
    end

    // the command pins are taken with the same filtered vector as the edge
    assign bus.rise = rise_ff;
    assign bus.ck_t = filt_ff[PIN_CK_T];
    assign bus.ck_c = filt_ff[PIN_CK_C];
    assign bus.cke  = filt_ff[PIN_CKE];
    assign bus.cs_n = filt_ff[PIN_CS_N];
    assign bus.ca   = filt_ff[2:0];

endmodule : link_sampler

// ==== logic/lpddr2_lp_clock_ctl.sv ====
`timescale 1ns/1ps
module lpddr2_lp_clock_ctl #(
    parameter int unsigned TXP_CK = 3           // exit delay in link clocks
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // link pins
    input  wire logic       ck_t_i,
    input  wire logic       ck_c_i,
    input  wire logic       cke_i,
    input  wire logic       cs_n_i,
    input  wire logic [2:0] ca_i,
    // core status from same-clock logic
    input  wire logic       op_busy_i,      // read, write or register access running
    input  wire logic       init_done_i,    // initialization sequence finished
    // state outputs
    output logic            in_dpd_o,
    output logic            pd_o,
    output logic            init_req_o,
    output logic            data_lost_o,
    output logic            ready_o,
    output logic            nop_o,
    output logic            clk_stopped_o,
    output logic            illegal_o,
    output logic            burst_run_o
);
    import lp_ctl_pkg::*;

    localparam logic [3:0] READY_EDGES = 4'(32'(MIN_EDGES) + TXP_CK); // two clocks plus exit delay

    // =====================================================================
    // decode helpers
    // =====================================================================
    function automatic logic is_nop(input logic cs_n, input logic [2:0] ca);
        is_nop = cs_n | (ca == CA_NOP);
    endfunction : is_nop

    function automatic logic is_dpd(input logic cs_n, input logic [2:0] ca);
        is_dpd = ~cs_n & (ca == CA_DPD);
    endfunction : is_dpd

    // =====================================================================
    // sampler
    // =====================================================================
    link_cmd_if u_link ();

    link_sampler u_sampler (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .ck_t_i  (ck_t_i),
        .ck_c_i  (ck_c_i),
        .cke_i   (cke_i),
        .cs_n_i  (cs_n_i),
        .ca_i    (ca_i),
        .bus     (u_link)
    );

    logic       rise;               // edge pulse gated by enable
    logic       cke;                // cke at this edge
    logic       nop_cmd;            // nop encoding seen
    logic       dpd_cmd;            // deep power-down encoding seen
    logic       cke_fall;           // high at last edge, low now
    logic       cke_rise;           // low at last edge, high now
    lp_state_t  state_ff;           // low-power state
    lp_state_t  nxt_state;          // next low-power state
    logic       cke_prev_ff;        // cke taken at previous edge
    logic [7:0] idle_ff;            // local cycles since last link edge
    logic       stopped_ff;         // link clock regarded as stopped
    logic       stop_seen_ff;       // stop happened during current cke-low stretch
    logic [3:0] edges_ff;           // link edges since last stop
    logic [3:0] low_edges_ff;       // link edges since cke fell
    logic       dpd_chk_ff;         // next edge must carry a nop
    logic       ill_set;            // an illegal event this cycle
    logic       ill_clr;            // re-initialization completed
    logic       stop_onset;         // idle counter reaches the stop limit
    logic       ready_ff;
    logic       nop_ff;
    logic       illegal_ff;
    logic       lost_ff;
    logic       burst_ff;
    logic       in_dpd_ff;
    logic       pd_ff;
    logic       init_ff;

    assign rise     = ce_i & u_link.rise;
    assign cke      = u_link.cke;
    assign nop_cmd  = is_nop(u_link.cs_n, u_link.ca);
    assign dpd_cmd  = is_dpd(u_link.cs_n, u_link.ca);
    assign cke_fall = cke_prev_ff & ~cke;
    assign cke_rise = ~cke_prev_ff & cke;
    assign stop_onset = ce_i & ~u_link.rise & ~stopped_ff & (idle_ff == STOP_CNT - 8'h01);

    // =====================================================================
    // low-power state machine
    // =====================================================================
    // a cke fall that is not the deep power-down encoding is treated as a
    // plain power-down hold; self refresh is not modelled here
    always_comb begin
        nxt_state = state_ff;
        if (rise) begin
            case (state_ff)
                ST_ACTIVE: begin
                    if (cke_fall && dpd_cmd) begin
                        nxt_state = ST_DPD;
                    end else if (cke_fall) begin
                        nxt_state = ST_PD;
                    end
                end
                ST_PD: begin
                    if (cke) begin
                        nxt_state = ST_ACTIVE;
                    end
                end
                ST_DPD: begin
                    // only a cke rise leaves; held low keeps us here
                    if (cke) begin
                        nxt_state = ST_INIT;
                    end
                end
                ST_INIT: begin
                    nxt_state = ST_INIT;
                end
                default: begin
                    nxt_state = ST_ACTIVE;
                end
            endcase
        end
        // initialization is owned by the core; only its completion releases us
        if (ce_i && state_ff == ST_INIT && init_done_i) begin
            nxt_state = ST_ACTIVE;
        end
    end

    // state register and decoded state flags
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff  <= ST_ACTIVE;
            in_dpd_ff <= 1'b0;
            pd_ff     <= 1'b0;
            init_ff   <= 1'b0;
        end else if (ce_i) begin
            state_ff  <= nxt_state;
            in_dpd_ff <= (nxt_state == ST_DPD);
            pd_ff     <= (nxt_state == ST_PD);
            init_ff   <= (nxt_state == ST_INIT);
        end
    end

    // =====================================================================
    // link clock watch
    // =====================================================================
    // a stop is only known after STOP_CYC quiet cycles, so checks tied to
    // the stop fire late; that is a limit of sampling the link clock
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_ff      <= 8'h00;
            stopped_ff   <= 1'b0;
            stop_seen_ff <= 1'b0;
            edges_ff     <= 4'h0;
            low_edges_ff <= 4'h0;
            cke_prev_ff  <= 1'b0;
        end else if (ce_i) begin
            if (u_link.rise) begin
                idle_ff     <= 8'h00;
                stopped_ff  <= 1'b0;
                cke_prev_ff <= cke;
                if (edges_ff != EDGE_SAT) begin
                    edges_ff <= edges_ff + 4'h1;
                end
                // edges spent at the original rate after cke falls
                if (cke_fall) begin
                    low_edges_ff <= 4'h0;
                end else if (!cke && low_edges_ff != EDGE_SAT) begin
                    low_edges_ff <= low_edges_ff + 4'h1;
                end
                if (cke) begin
                    stop_seen_ff <= 1'b0;
                end
            end else if (stop_onset) begin
                stopped_ff <= 1'b1;
                edges_ff   <= 4'h0;
                if (!cke) begin
                    stop_seen_ff <= 1'b1;
                end
            end else if (!stopped_ff) begin
                idle_ff <= idle_ff + 8'h01;
            end
        end
    end

    // =====================================================================
    // illegal-event detection
    // =====================================================================
    always_comb begin
        ill_set = 1'b0;
        if (rise) begin
            if (dpd_chk_ff && !nop_cmd) begin
                ill_set = 1'b1;
            end
            if (cke_fall && op_busy_i) begin
                ill_set = 1'b1;
            end
            if (cke_rise && stop_seen_ff && edges_ff < MIN_EDGES) begin
                ill_set = 1'b1;
            end
        end
        if (stop_onset) begin
            if (!cke && low_edges_ff < MIN_EDGES) begin
                ill_set = 1'b1;
            end
            if (u_link.ck_t || !u_link.ck_c) begin
                ill_set = 1'b1;
            end
            // refresh is not part of op_busy, so it may keep running
            if (op_busy_i) begin
                ill_set = 1'b1;
            end
        end
        if (ce_i && stopped_ff && cke && !u_link.cs_n) begin
            ill_set = 1'b1;
        end
    end

    // a full re-initialization is the only way out of the illegal flag
    assign ill_clr = ce_i & (state_ff == ST_INIT) & init_done_i;

    // sticky illegal and lost flags, plus the post-entry nop check; a new event wins over the clearing completion
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            illegal_ff <= 1'b0;
            lost_ff    <= 1'b0;
            dpd_chk_ff <= 1'b0;
        end else if (ce_i) begin
            illegal_ff <= ill_set | (illegal_ff & ~ill_clr);
            if (nxt_state == ST_DPD && state_ff != ST_DPD) begin
                lost_ff <= 1'b1;
            end else if (ill_clr) begin
                lost_ff <= 1'b0;
            end
            if (rise) begin
                dpd_chk_ff <= (nxt_state == ST_DPD) && (state_ff != ST_DPD);
            end
        end
    end

    // =====================================================================
    // command status outputs
    // =====================================================================
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nop_ff   <= 1'b0;
            burst_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else if (ce_i) begin
            nop_ff   <= rise & nop_cmd & (cke == cke_prev_ff);
            // a nop never touches a running burst
            burst_ff <= op_busy_i;
            // a restart must show MIN_EDGES plus the exit delay first;
            // latency updates after a rate change stay with the core
            ready_ff <= (nxt_state == ST_ACTIVE) && !stopped_ff &&
                        (edges_ff >= READY_EDGES) && !illegal_ff;
        end
    end

    assign in_dpd_o      = in_dpd_ff;
    assign pd_o          = pd_ff;
    assign init_req_o    = init_ff;
    assign data_lost_o   = lost_ff;
    assign ready_o       = ready_ff;
    assign nop_o         = nop_ff;
    assign clk_stopped_o = stopped_ff;
    assign illegal_o     = illegal_ff;
    assign burst_run_o   = burst_ff;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_dpd_entry_state: assert property (
        rise && state_ff == ST_ACTIVE && cke_fall && dpd_cmd |=> in_dpd_o && data_lost_o)
        else $error("deep power-down entry not taken");
    a_post_entry_nop: assert property (
        rise && dpd_chk_ff && !nop_cmd |=> illegal_o)
        else $error("missing nop after entry not flagged");
    a_cke_busy_fall: assert property (
        rise && cke_fall && op_busy_i |=> illegal_o)
        else $error("cke fall during access not flagged");
    a_dpd_exit_init: assert property (
        rise && state_ff == ST_DPD && cke |=> init_req_o && !in_dpd_o ##1 !ready_o)
        else $error("deep power-down exit wrong");
    a_init_hold: assert property (
        init_req_o && !init_done_i |=> init_req_o && !ready_o)
        else $error("left initialization early");
    a_nop_same_cke: assert property (
        rise && cke != cke_prev_ff |=> !nop_o)
        else $error("nop reported across cke change");
    a_nop_decode: assert property (
        rise && cke == cke_prev_ff && (u_link.cs_n || u_link.ca == CA_NOP) |=> nop_o)
        else $error("nop not decoded");
    a_illegal_sticky: assert property (
        illegal_o && !(ce_i && state_ff == ST_INIT && init_done_i) |=> illegal_o)
        else $error("illegal flag dropped");
    a_ready_edges: assert property (
        $rose(ready_o) |-> edges_ff >= READY_EDGES)
        else $error("ready before stable clocks");
    a_burst_kept: assert property (
        ce_i && op_busy_i && rise && nop_cmd |=> burst_run_o)
        else $error("burst dropped on nop");

    c_dpd_entry: cover property (rise && state_ff == ST_ACTIVE && cke_fall && dpd_cmd);
    c_dpd_exit:  cover property (init_req_o ##1 !init_req_o);
    c_stop:      cover property ($rose(clk_stopped_o));
    c_ready:     cover property ($rose(ready_o));

endmodule : lpddr2_lp_clock_ctl

// ==== test/lpddr2_host_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// controller side of the link
// =====================================================================
module lpddr2_host_model (
    // link pins toward the device
    output logic       ck_t_o,
    output logic       ck_c_o,
    output logic       cke_o,
    output logic       cs_n_o,
    output logic [2:0] ca_o
);
    // the clock parks between frames, so the device may see a stop
    initial begin
        ck_t_o = 1'b0;
        ck_c_o = 1'b1;
        cke_o  = 1'b0;
        cs_n_o = 1'b1;
        ca_o   = 3'h0;
    end

    // one link cycle: pins change while ck_t is low and hold through the rise
    task automatic cycle(input logic cke, input logic cs_n, input logic [2:0] ca);
        #37;
        cke_o  = cke;
        cs_n_o = cs_n;
        // deselected ca is don't care: show the inverse, never a stale copy
        ca_o   = cs_n ? ~ca_o : ca;
        // one fixed period only, so no rate change and no latency update
        #400 ck_t_o = 1'b1;
        ck_c_o = 1'b0;
        #400 ck_t_o = 1'b0;
        ck_c_o = 1'b1;
    endtask : cycle

    // clock stop: true low, complement high, chip select as commanded
    // called on a local clock edge, so the pins move by non-blocking update
    task automatic stop(input int ns, input logic cs_n);
        cs_n_o <= cs_n;
        ck_t_o <= 1'b0;
        ck_c_o <= 1'b1;
        #(ns);
    endtask : stop
endmodule : lpddr2_host_model

// ==== test/lpddr2_low_power_clock_ctl_tb_top.sv ====
`timescale 1ns/1ps
module lpddr2_low_power_clock_ctl_tb_top;
    // =====================================================================
    // signals
    // =====================================================================
    localparam int TXP = 3;        // exit delay handed to the design
    logic       clock_i = 1'b0;    // local clock
    logic       rst_n_i;           // reset, active low
    logic       ce_i;              // clock enable
    logic       op_busy_i;         // core busy
    logic       init_done_i;       // init finished
    logic       ck_t, ck_c, cke, cs_n;
    logic [2:0] ca;
    logic       in_dpd_o, pd_o, init_req_o, data_lost_o, ready_o;
    logic       nop_o, clk_stopped_o, illegal_o, burst_run_o;
    int         error_cnt = 0;     // mismatches
    int         num_checks = 0;    // comparisons
    int         nop_cnt = 0;       // nop pulses seen
    int         seed;              // random seed
    logic       prev_cke = 1'b0;   // cke at the previous link edge

    always #50 clock_i = ~clock_i;

    // count nop pulses so each link edge can be judged on its own
    always @(posedge clock_i) begin
        if (nop_o === 1'b1) nop_cnt <= nop_cnt + 1;
    end

    lpddr2_host_model host_u (.ck_t_o(ck_t), .ck_c_o(ck_c), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));

    lpddr2_lp_clock_ctl #(.TXP_CK(TXP)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .ck_t_i(ck_t), .ck_c_i(ck_c),
        .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca), .op_busy_i(op_busy_i), .init_done_i(init_done_i),
        .in_dpd_o(in_dpd_o), .pd_o(pd_o), .init_req_o(init_req_o), .data_lost_o(data_lost_o),
        .ready_o(ready_o), .nop_o(nop_o), .clk_stopped_o(clk_stopped_o), .illegal_o(illegal_o),
        .burst_run_o(burst_run_o));

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // one link edge, then enough local cycles for the answer to land
    task automatic link_cmd(input logic k, input logic c, input logic [2:0] a);
        int  base;
        logic exp;
        base = nop_cnt;
        // a nop counts only with cke unchanged across the two edges
        exp = (prev_cke === k) && (c || a == 3'h7);
        prev_cke = k;
        host_u.cycle(k, c, a);
        repeat (4) @(posedge clock_i);
        check(8'(nop_cnt - base), {7'h0, exp});
    endtask : link_cmd

    // five nop edges; exact also checks the moment ready rises
    task automatic warm(input logic exact);
        for (int i = 0; i < 2 + TXP; i++) begin
            link_cmd(1'b1, 1'b1, 3'h7);
            if (exact || i == 1 + TXP) check(ready_o, i == 1 + TXP);
        end
    endtask : warm

    // deep power-down entry, follow-up, optional stop, exit and init
    task automatic dpd_seq(input logic bad, input logic ill);
        link_cmd(1'b1, 1'b1, 3'h7);
        link_cmd(1'b0, 1'b0, 3'h3);
        check(in_dpd_o, 1'b1);
        check(data_lost_o, 1'b1);
        // a bad follow-up keeps chip select low with a code that is no nop
        link_cmd(1'b0, 1'b0, bad ? 3'h2 : 3'h7);
        check(illegal_o, ill);
        link_cmd(1'b0, 1'b1, 3'h7);
        if (!bad) begin
            // two original clocks were given before the stop
            host_u.stop(3000, 1'b1);
            check(clk_stopped_o, 1'b1);
            link_cmd(1'b0, 1'b1, 3'h7);
            link_cmd(1'b0, 1'b1, 3'h7);
        end
        check(in_dpd_o, 1'b1);
        link_cmd(1'b1, 1'b1, 3'h7);
        check(in_dpd_o, 1'b0);
        check(init_req_o, 1'b1);
        init_done_i <= 1'b1;
        @(posedge clock_i);
        init_done_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check({init_req_o, data_lost_o, illegal_o}, 8'h00);
    endtask : dpd_seq

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        seed = 9528;
        rst_n_i = 1'b0;
        ce_i = 1'b0;
        op_busy_i = 1'b0;
        init_done_i = 1'b0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        ce_i <= 1'b1;
        @(posedge clock_i);
        check({in_dpd_o, pd_o, init_req_o, data_lost_o, ready_o, illegal_o}, 8'h00);
        warm(1'b1);
        // random commands with cke steady, corner encodings first
        for (int i = 0; i < 24; i++) begin
            op_busy_i <= 1'($random(seed));
            link_cmd(1'b1, (i < 2) ? 1'b0 : 1'($random(seed)), (i == 0) ? 3'h7 : 3'($random(seed)));
            check(burst_run_o, op_busy_i);
        end
        op_busy_i <= 1'b0;
        check(ready_o, 1'b1);
        // plain power-down entry and exit carry no nop
        link_cmd(1'b0, 1'b1, 3'h5);
        check(pd_o, 1'b1);
        link_cmd(1'b0, 1'b1, 3'h7);
        link_cmd(1'b1, 1'b1, 3'h7);
        check(pd_o, 1'b0);
        dpd_seq(1'b0, 1'b0);
        dpd_seq(1'b1, 1'b1);
        // cke falling during a busy core is flagged illegal
        warm(1'b0);
        op_busy_i <= 1'b1;
        link_cmd(1'b0, 1'b1, 3'h7);
        check(illegal_o, 1'b1);
        op_busy_i <= 1'b0;
        link_cmd(1'b1, 1'b1, 3'h7);
        dpd_seq(1'b0, 1'b1);
        // clock stop with cke high, then ready after the restart count
        warm(1'b0);
        host_u.stop(3000, 1'b1);
        check({clk_stopped_o, ready_o}, 8'h02);
        warm(1'b1);
        check(illegal_o, 1'b0);
        // enable low freezes the stop watch, so ready keeps standing
        ce_i <= 1'b0;
        host_u.stop(3000, 1'b1);
        check({clk_stopped_o, ready_o}, 8'h01);
        ce_i <= 1'b1;
        host_u.stop(3000, 1'b0);
        check(illegal_o, 1'b1);
        // re-initialize, then stop the clock while the core is still busy
        dpd_seq(1'b0, 1'b1);
        op_busy_i <= 1'b1;
        host_u.stop(3000, 1'b1);
        check(illegal_o, 1'b1);
        op_busy_i <= 1'b0;
        end_sim();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock_i);
        error_cnt++;
        end_sim();
    end
endmodule : lpddr2_low_power_clock_ctl_tb_top
